// *** mpwm_pkg.sv ***
package mpwm_pkg;
   localparam int MPWM_NUM_MATCH = 7;
   localparam int MPWM_NUM_OUT = 6;
   localparam int MPWM_WIDTH = 32;
   localparam int MPWM_CYCLE_IDX = 0;
   // Per-match control field positions
   localparam int MPWM_ACT_INT = 0;
   localparam int MPWM_ACT_RST = 1;
   localparam int MPWM_ACT_STOP = 2;
   localparam logic [31:0] MPWM_ZERO = 32'h0000_0000;
   localparam logic [31:0] MPWM_ONE = 32'h0000_0001;
   typedef enum logic [1:0] {
      MPWM_IDLE = 2'b00,
      MPWM_RUN = 2'b01,
      MPWM_HALT = 2'b11
   } mpwm_state_t;
endpackage : mpwm_pkg

// *** mpwm_shadow_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface mpwm_shadow_if;
   import mpwm_pkg::*;
   logic [MPWM_NUM_MATCH-1:0] wr_en;
   logic [MPWM_WIDTH-1:0] wr_data;
   logic [MPWM_NUM_MATCH-1:0] release_mask;
   logic load;
   logic [MPWM_NUM_MATCH*MPWM_WIDTH-1:0] active;
   logic [MPWM_NUM_MATCH-1:0] pending;
   modport owner (output wr_en, wr_data, release_mask, load, input active, pending);
   modport store (input wr_en, wr_data, release_mask, load, output active, pending);
endinterface : mpwm_shadow_if
`default_nettype wire

// *** mpwm_match_store.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpwm_match_store
   import mpwm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Shadow port
   mpwm_shadow_if.store sh
);
   logic [MPWM_WIDTH-1:0] shadow_reg [MPWM_NUM_MATCH];
   logic [MPWM_WIDTH-1:0] shadow_next [MPWM_NUM_MATCH];
   logic [MPWM_WIDTH-1:0] active_reg [MPWM_NUM_MATCH];
   logic [MPWM_WIDTH-1:0] active_next [MPWM_NUM_MATCH];
   logic [MPWM_NUM_MATCH-1:0] latch_reg, latch_next;

   always_comb begin
      for (int i = 0; i < MPWM_NUM_MATCH; i++) begin
         shadow_next[i] = sh.wr_en[i] ? sh.wr_data : shadow_reg[i];
         active_next[i] = active_reg[i];
         if (sh.load && latch_reg[i]) begin
            active_next[i] = shadow_reg[i]; // R12
         end
      end
      // Release set wins over the transfer that clears it
      latch_next = (sh.load ? '0 : latch_reg) | sh.release_mask; // R7
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < MPWM_NUM_MATCH; i++) begin
            shadow_reg[i] <= MPWM_ZERO;
            active_reg[i] <= MPWM_ZERO;
         end
         latch_reg <= '0;
      end else begin
         shadow_reg <= shadow_next;
         active_reg <= active_next;
         latch_reg <= latch_next;
      end
   end

   always_comb begin
      for (int i = 0; i < MPWM_NUM_MATCH; i++) begin
         sh.active[i*MPWM_WIDTH +: MPWM_WIDTH] = active_reg[i];
      end
      sh.pending = latch_reg;
   end
endmodule : mpwm_match_store
`default_nettype wire

// *** mpwm_timer.sv ***
// Contract
// (R1) Seven match registers give six single-edge or three double-edge outputs, or a mix.
// (R2) Each match may continue, stop or reset the counter, optional interrupt.
// (R3) Single-edge outputs rise at each cycle start unless held low.
// (R4) Double-edge outputs place both edges anywhere, positive or negative pulses.
// (R5) Period and width are any whole tick count; one shared repetition rate.
// (R6) Match updates are synchronous to pulse outputs, no truncated pulses.
// (R7) Software releases new match values; old ones stay until released.
// (R8) Counter ticks on clock or edges of a selected capture input.
// (R9) With PWM off, plain 32-bit timer/counter with 32-bit prescaler.
// (R10) Cycle-length match resets counter; single-edge outputs rise there, fall at own match.
// (R11) Double-edge output: one match sets rise, another sets fall.
// (R12) Released values load into active compares at the next cycle-length reset.
`timescale 1ns/1ps
`default_nettype none
module mpwm_timer
   import mpwm_pkg::*;
#(
   parameter int NUM_CAP = 2
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Control
   input wire logic COUNT_ENABLE,
   input wire logic COUNTER_RESET,
   input wire logic PWM_ENABLE,
   input wire logic COUNTER_MODE,
   input wire logic [1:0] EDGE_SELECT,
   input wire logic [$clog2(NUM_CAP)-1:0] CAP_SELECT,
   input wire logic [MPWM_WIDTH-1:0] PRESCALE,
   // Match programming
   input wire logic [MPWM_NUM_MATCH-1:0] MATCH_WRITE,
   input wire logic [MPWM_WIDTH-1:0] MATCH_DATA,
   input wire logic [MPWM_NUM_MATCH-1:0] MATCH_RELEASE,
   input wire logic [3*MPWM_NUM_MATCH-1:0] MATCH_ACTION,
   // Output configuration
   input wire logic [MPWM_NUM_OUT-1:0] DOUBLE_EDGE,
   input wire logic [MPWM_NUM_OUT-1:0] OUT_ENABLE,
   // Capture pins
   input wire logic [NUM_CAP-1:0] CAP_PIN,
   // Status
   output logic [MPWM_WIDTH-1:0] COUNT_VALUE,
   output logic [MPWM_NUM_MATCH-1:0] MATCH_EVENT,
   output logic [MPWM_NUM_MATCH-1:0] RELEASE_PENDING,
   output logic RUNNING,
   // PWM outputs
   output logic [MPWM_NUM_OUT-1:0] PWM_OUT
);
   mpwm_shadow_if sh ();

   mpwm_match_store mpwm_match_store_inst (
      .clk(CLK),
      .rst(SYS_RST),
      .sh(sh)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Capture input synchronisers and edge detect

   logic [NUM_CAP-1:0] cap_s1_reg, cap_s2_reg, cap_s3_reg;
   logic cap_edge;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         cap_s1_reg <= '0;
         cap_s2_reg <= '0;
         cap_s3_reg <= '0;
      end else begin
         cap_s1_reg <= CAP_PIN;
         cap_s2_reg <= cap_s1_reg;
         cap_s3_reg <= cap_s2_reg;
      end
   end

   // Edge select: bit 0 rising, bit 1 falling
   always_comb begin
      cap_edge = (EDGE_SELECT[0] && cap_s2_reg[CAP_SELECT] && !cap_s3_reg[CAP_SELECT]) ||
                 (EDGE_SELECT[1] && !cap_s2_reg[CAP_SELECT] && cap_s3_reg[CAP_SELECT]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler and counter

   mpwm_state_t state_reg, state_next;
   logic [MPWM_WIDTH-1:0] pre_reg, pre_next, cnt_reg, cnt_next;
   logic [MPWM_NUM_OUT-1:0] out_reg, out_next;
   logic [MPWM_NUM_MATCH-1:0] hit;
   logic tick, pre_wrap, any_rst, any_stop, cycle_rst;

   function automatic logic [MPWM_WIDTH-1:0] match_val(input logic [MPWM_NUM_MATCH*MPWM_WIDTH-1:0] v,
                                                     input int idx);
      match_val = v[idx*MPWM_WIDTH +: MPWM_WIDTH];
   endfunction : match_val

   always_comb begin
      // Counter mode bypasses the prescaler so each selected edge is one count
      tick = COUNTER_MODE ? cap_edge : 1'b1; // R8
      pre_wrap = tick && (COUNTER_MODE || pre_reg >= PRESCALE); // R9
      for (int i = 0; i < MPWM_NUM_MATCH; i++) begin
         hit[i] = (state_reg == MPWM_RUN) && pre_wrap && (cnt_reg == match_val(sh.active, i));
      end
      any_rst = 1'b0;
      any_stop = 1'b0;
      for (int i = 0; i < MPWM_NUM_MATCH; i++) begin
         any_rst = any_rst | (hit[i] && MATCH_ACTION[3*i+MPWM_ACT_RST]); // R2
         any_stop = any_stop | (hit[i] && MATCH_ACTION[3*i+MPWM_ACT_STOP]); // R2
      end
      // In PWM mode the cycle-length match always ends the period
      if (PWM_ENABLE && hit[MPWM_CYCLE_IDX]) begin
         any_rst = 1'b1; // R10 R5
      end
      cycle_rst = PWM_ENABLE && hit[MPWM_CYCLE_IDX];

      state_next = state_reg;
      pre_next = pre_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         MPWM_IDLE: begin
            if (COUNT_ENABLE) begin
               state_next = MPWM_RUN;
            end
         end
         MPWM_RUN: begin
            if (!COUNT_ENABLE) begin
               state_next = MPWM_IDLE;
            end else if (tick) begin
               pre_next = pre_wrap ? MPWM_ZERO : pre_reg + MPWM_ONE;
               if (pre_wrap) begin
                  cnt_next = any_rst ? MPWM_ZERO : cnt_reg + MPWM_ONE;
               end
               if (any_stop) begin
                  state_next = MPWM_HALT;
               end
            end
         end
         MPWM_HALT: begin
            // Stop on match holds here until software drops COUNT_ENABLE; raising it again restarts
            if (!COUNT_ENABLE) begin
               state_next = MPWM_IDLE;
            end
         end
         default: state_next = MPWM_IDLE;
      endcase
      if (COUNTER_RESET) begin
         pre_next = MPWM_ZERO;
         cnt_next = MPWM_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PWM output logic

   always_comb begin
      out_next = out_reg;
      for (int n = 1; n <= MPWM_NUM_OUT; n++) begin
         if (!PWM_ENABLE || !OUT_ENABLE[n-1]) begin
            out_next[n-1] = 1'b0;
         end else if (DOUBLE_EDGE[n-1] && n >= MPWM_CYCLE_IDX + 2) begin
            // Rise on match n-1, fall on match n; order decides polarity
            if (hit[n]) begin
               out_next[n-1] = 1'b0; // R11 R4
            end else if (hit[n-1]) begin
               out_next[n-1] = 1'b1; // R11 R4
            end
         end else begin
            // An edge match of zero suppresses the rise, so the output stays constantly low
            if (hit[n]) begin
               out_next[n-1] = 1'b0; // R10 R1
            end else if (cycle_rst) begin
               out_next[n-1] = (match_val(sh.active, n) != MPWM_ZERO); // R3
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_reg <= MPWM_IDLE;
         pre_reg <= MPWM_ZERO;
         cnt_reg <= MPWM_ZERO;
         out_reg <= '0;
      end else begin
         state_reg <= state_next;
         pre_reg <= pre_next;
         cnt_reg <= cnt_next;
         out_reg <= out_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shadow control; transfer at the cycle boundary, or at once while PWM is off

   always_comb begin
      sh.wr_en = MATCH_WRITE;
      sh.wr_data = MATCH_DATA;
      sh.release_mask = MATCH_RELEASE; // R7
      sh.load = cycle_rst || !PWM_ENABLE; // R6 R12
   end

   always_comb begin
      COUNT_VALUE = cnt_reg;
      PWM_OUT = out_reg;
      RUNNING = (state_reg == MPWM_RUN);
      RELEASE_PENDING = sh.pending;
      for (int i = 0; i < MPWM_NUM_MATCH; i++) begin
         MATCH_EVENT[i] = hit[i] && MATCH_ACTION[3*i+MPWM_ACT_INT]; // R2
      end
   end
endmodule : mpwm_timer
`default_nettype wire

// *** mpwm_timer_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpwm_timer_props
   import mpwm_pkg::*;
#(
   parameter int NUM_CAP = 2
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Control
   input wire logic COUNT_ENABLE,
   input wire logic COUNTER_RESET,
   input wire logic PWM_ENABLE,
   input wire logic COUNTER_MODE,
   input wire logic [MPWM_WIDTH-1:0] PRESCALE,
   input wire logic [MPWM_NUM_MATCH-1:0] MATCH_RELEASE,
   input wire logic [3*MPWM_NUM_MATCH-1:0] MATCH_ACTION,
   input wire logic [MPWM_NUM_OUT-1:0] OUT_ENABLE,
   input wire logic [NUM_CAP-1:0] CAP_PIN,
   // Status and outputs
   input wire logic [MPWM_WIDTH-1:0] COUNT_VALUE,
   input wire logic [MPWM_NUM_MATCH-1:0] MATCH_EVENT,
   input wire logic [MPWM_NUM_MATCH-1:0] RELEASE_PENDING,
   input wire logic RUNNING,
   input wire logic [MPWM_NUM_OUT-1:0] PWM_OUT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   ////////////////////////////////////////////////////////////
   a_cnt_clear: assert property (COUNTER_RESET |=> COUNT_VALUE == MPWM_ZERO)
      else $error("counter not cleared");
   a_cnt_step: assert property ((RUNNING && COUNT_ENABLE && !PWM_ENABLE && !COUNTER_MODE && !COUNTER_RESET
      && PRESCALE == MPWM_ZERO && MATCH_ACTION == '0) |=> COUNT_VALUE == $past(COUNT_VALUE) + MPWM_ONE)
      else $error("counter did not step by one");
   // Synchroniser delay means four quiet cycles before the count must hold
   a_cap_idle: assert property ((COUNTER_MODE && !PWM_ENABLE && !COUNTER_RESET && MATCH_ACTION == '0
      && $stable(CAP_PIN))[*4] |=> $stable(COUNT_VALUE)) else $error("count moved without capture edge");
   a_stop_halt: assert property (MATCH_EVENT[1] && MATCH_ACTION[5] |=> !RUNNING)
      else $error("stop match did not halt");
   a_halt_hold: assert property (!RUNNING && !COUNTER_RESET |=> $stable(COUNT_VALUE))
      else $error("stopped counter moved");
   a_cycle_zero: assert property (MATCH_EVENT[0] && PWM_ENABLE |=> COUNT_VALUE == MPWM_ZERO)
      else $error("cycle match did not restart count");
   a_single_rise: assert property (MATCH_EVENT[0] && PWM_ENABLE && OUT_ENABLE[0] |=> PWM_OUT[0])
      else $error("single edge output did not rise");
   a_out_off: assert property (1'b1 |=> (PWM_OUT & ~$past(OUT_ENABLE)) == '0)
      else $error("disabled output driven high");
   a_pend_set: assert property (PWM_ENABLE && MATCH_RELEASE != '0
      |=> (RELEASE_PENDING & $past(MATCH_RELEASE)) == $past(MATCH_RELEASE)) else $error("release not pending");
   a_pend_keep: assert property ($past(PWM_ENABLE) && ($past(RELEASE_PENDING) & ~RELEASE_PENDING) != '0
      |-> COUNT_VALUE == MPWM_ZERO) else $error("transfer outside cycle start");
   c_cycle: cover property (MATCH_EVENT[0]);
   c_pend: cover property (RELEASE_PENDING != '0);
   c_halt: cover property (COUNT_ENABLE && !RUNNING);
endmodule : mpwm_timer_props
`default_nettype wire

// *** mpwm_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpwm_timer_tb;
   import mpwm_pkg::*;
   logic CLK, SYS_RST, COUNT_ENABLE, COUNTER_RESET, PWM_ENABLE, COUNTER_MODE, RUNNING;
   logic [1:0] EDGE_SELECT, CAP_PIN;
   logic [0:0] CAP_SELECT;
   logic [MPWM_WIDTH-1:0] PRESCALE, MATCH_DATA, COUNT_VALUE, v;
   logic [MPWM_NUM_MATCH-1:0] MATCH_WRITE, MATCH_RELEASE, MATCH_EVENT, RELEASE_PENDING;
   logic [3*MPWM_NUM_MATCH-1:0] MATCH_ACTION;
   logic [MPWM_NUM_OUT-1:0] DOUBLE_EDGE, OUT_ENABLE, PWM_OUT;
   int miscompares, samples_checked;
   mpwm_timer #(.NUM_CAP(2)) mpwm_timer_inst (.CLK, .SYS_RST, .COUNT_ENABLE, .COUNTER_RESET, .PWM_ENABLE,
      .COUNTER_MODE, .EDGE_SELECT, .CAP_SELECT, .PRESCALE, .MATCH_WRITE, .MATCH_DATA, .MATCH_RELEASE,
      .MATCH_ACTION, .DOUBLE_EDGE, .OUT_ENABLE, .CAP_PIN, .COUNT_VALUE, .MATCH_EVENT, .RELEASE_PENDING,
      .RUNNING, .PWM_OUT);
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : cmp32
   task automatic tick(input int n);
      repeat (n) @(negedge CLK);
   endtask : tick
   task automatic wr(input int i, input logic [31:0] d);
      MATCH_WRITE = 7'h01 << i;
      MATCH_DATA = d;
      tick(1);
      MATCH_WRITE = '0;
   endtask : wr
   task automatic rel(input logic [6:0] m);
      MATCH_RELEASE = m;
      tick(1);
      MATCH_RELEASE = '0;
   endtask : rel
   // High cycles of output k over the next whole period of ten counts
   task automatic high(input int k, input logic [31:0] exp);
      logic [31:0] h;
      h = '0;
      tick(2);
      for (int t = 0; t < 40 && COUNT_VALUE !== '0; t++) tick(1);
      if (COUNT_VALUE !== '0) begin
         miscompares++;
         complete_run;
      end
      repeat (10) begin
         h = h + 32'(PWM_OUT[k]);
         tick(1);
      end
      cmp32(h, exp);
   endtask : high
   ////////////////////////////////////////////////////////////
   task automatic test_timer;
      COUNT_ENABLE = 1'b1;
      tick(3);
      v = COUNT_VALUE;
      tick(5);
      cmp32(COUNT_VALUE, v + 32'h5);
      PRESCALE = 32'h2;
      tick(1);
      v = COUNT_VALUE;
      tick(6);
      cmp32(COUNT_VALUE, v + 32'h2);
      PRESCALE = '0;
      COUNTER_RESET = 1'b1;
      tick(1);
      COUNTER_RESET = 1'b0;
      cmp32(COUNT_VALUE, '0);
      $display("timer test done");
   endtask : test_timer
   task automatic test_pwm;
      OUT_ENABLE = 6'h3f;
      PWM_ENABLE = 1'b1;
      wr(0, 32'h9);
      wr(1, 32'h4);
      rel(7'h03);
      high(0, 32'h5);
      MATCH_ACTION = 21'h1;
      wr(1, 32'h7);
      high(0, 32'h5);
      rel(7'h02);
      cmp32(32'(RELEASE_PENDING), 32'h2);
      high(0, 32'h8);
      cmp32(32'(RELEASE_PENDING), '0);
      $display("pwm test done");
   endtask : test_pwm
   task automatic test_double;
      DOUBLE_EDGE = 6'h04;
      wr(2, 32'h2);
      wr(3, 32'h6);
      rel(7'h0c);
      high(2, 32'h4);
      wr(2, 32'h6);
      wr(3, 32'h2);
      rel(7'h0c);
      tick(10);
      high(2, 32'h6);
      $display("double edge test done");
   endtask : test_double
   task automatic test_stop_count;
      MATCH_ACTION = 21'h28;
      tick(12);
      v = COUNT_VALUE;
      tick(3);
      cmp32(COUNT_VALUE, v);
      cmp32(32'(RUNNING), '0);
      {COUNT_ENABLE, PWM_ENABLE, COUNTER_RESET} = 3'b001;
      MATCH_ACTION = '0;
      tick(1);
      {COUNT_ENABLE, COUNTER_RESET, COUNTER_MODE, EDGE_SELECT, CAP_SELECT} = 6'b101011;
      tick(4);
      v = COUNT_VALUE;
      repeat (3) begin
         CAP_PIN = 2'b10;
         tick(3);
         CAP_PIN = 2'b01;
         tick(3);
      end
      tick(4);
      cmp32(COUNT_VALUE, v + 32'h3);
      $display("stop and count test done");
   endtask : test_stop_count
   initial begin
      {SYS_RST, COUNT_ENABLE, COUNTER_RESET, PWM_ENABLE, COUNTER_MODE} = 5'b10000;
      {EDGE_SELECT, CAP_PIN, CAP_SELECT, PRESCALE, MATCH_DATA} = '0;
      {MATCH_WRITE, MATCH_RELEASE, MATCH_ACTION, DOUBLE_EDGE, OUT_ENABLE} = '0;
      miscompares = 0;
      samples_checked = 0;
      tick(6);
      SYS_RST = 1'b0;
      cmp32(COUNT_VALUE | 32'(PWM_OUT), '0);
      test_timer();
      test_pwm();
      test_double();
      test_stop_count();
      complete_run();
   end
endmodule : mpwm_timer_tb
bind mpwm_timer mpwm_timer_props #(.NUM_CAP(NUM_CAP)) mpwm_timer_props_inst (.CLK, .SYS_RST, .COUNT_ENABLE,
   .COUNTER_RESET, .PWM_ENABLE, .COUNTER_MODE, .PRESCALE, .MATCH_RELEASE, .MATCH_ACTION, .OUT_ENABLE,
   .CAP_PIN, .COUNT_VALUE, .MATCH_EVENT, .RELEASE_PENDING, .RUNNING, .PWM_OUT);
`default_nettype wire
